//--- verilog/mfb_pkg.sv
// shared constants, op codes, states and word layouts of the math function block
// assumes a single 250 MHz clock and an AXI4-Lite register port with 32-bit data
package mfb_pkg;

  localparam int NUM_INST  = 5;
  localparam int NUM_IN    = 6;
  localparam int NUM_STG   = 4;
  localparam int NUM_SRC   = 16;
  localparam int GAIN_FRAC = 8;

  // percentages in hundredths of a percent
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [15:0] PCT_UNIT = 16'h0064;
  localparam logic [15:0] VAL_MAX  = 16'hffff;

  // word steps inside one instance's block of configuration
  localparam logic [4:0] STEP_FIRST = 5'h00;
  localparam logic [4:0] STEP_STG0  = 5'h0c;
  localparam logic [4:0] STEP_OUT   = 5'h10;

  localparam int          AXI_AW      = 12;
  localparam int          MEM_AW      = 8;
  localparam int          MEM_DEPTH   = 160;
  localparam logic [11:0] CFG_END     = 12'h280;
  localparam logic [11:0] RES_BASE    = 12'h400;
  localparam logic [11:0] RES_END     = 12'h414;
  localparam logic [11:0] CTRL_ADDR   = 12'h480;
  localparam logic [11:0] STAT_ADDR   = 12'h484;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_OR, OP_AND,
    OP_XOR, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MIN, OP_MAX
  } mfb_op_type;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} mfb_state_type;

  typedef struct packed {
    logic [15:0] max;
    logic [15:0] min;
  } mfb_lim_type;

  typedef struct packed {
    logic [15:0] gain;
    logic [7:0]  rsv;
    logic [7:0]  src;
  } mfb_src_type;

  typedef struct packed {
    logic [19:0] rsv;
    logic [3:0]  srcb;
    logic [3:0]  srca;
    logic [3:0]  op;
  } mfb_stage_type;

endpackage

//--- verilog/mfb_cfg_mem.sv
// configuration word store: one byte-masked write port, two registered read ports
// assumes the writer and both readers share one clock; contents are not reset
`timescale 1ns/1ps
module mfb_cfg_mem #(
  parameter int DEPTH = 160,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic [AW-1:0] raddr_a,
  output      logic [31:0]   rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output      logic [31:0]   rdata_b
);
  logic [31:0] mem [DEPTH];

  for (genvar b = 0; b < 4; b++) begin : g_lane
    always_ff @(posedge clk) begin
      if (we && wstrb[b] && int'(waddr) < DEPTH) begin
        mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata_a <= (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
    rdata_b <= (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
  end
endmodule

//--- verilog/mfb_alu.sv
// one operator stage: relational, logical, saturating arithmetic, min and max on percentages
// assumes operands in hundredths of a percent; purely combinational
`timescale 1ns/1ps
module mfb_alu (
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic [3:0]  op,
  output      logic [15:0] y
);
  logic        ta;
  logic        tb;
  logic [31:0] wide;

  always_comb begin
    ta   = a >= mfb_pkg::PCT_UNIT; // RULE9
    tb   = b >= mfb_pkg::PCT_UNIT; // RULE9
    wide = '0;
    y    = '0;
    unique case (mfb_pkg::mfb_op_type'(op)) // RULE16
      mfb_pkg::OP_EQ:  y = (a == b) ? mfb_pkg::PCT_UNIT : '0; // RULE8
      mfb_pkg::OP_NE:  y = (a != b) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_GT:  y = (a > b) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_GE:  y = (a >= b) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_LT:  y = (a < b) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_LE:  y = (a <= b) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_OR:  y = (ta || tb) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_AND: y = (ta && tb) ? mfb_pkg::PCT_UNIT : '0;
      mfb_pkg::OP_XOR: y = (ta ^ tb) ? mfb_pkg::PCT_UNIT : '0; // RULE13
      mfb_pkg::OP_ADD: wide = 32'(a) + 32'(b); // RULE12
      mfb_pkg::OP_SUB: wide = (a > b) ? 32'(a - b) : '0;
      mfb_pkg::OP_MUL: wide = (32'(a) * 32'(b)) / 32'(mfb_pkg::PCT_FULL);
      mfb_pkg::OP_DIV: wide = (b == '0) ? 32'(mfb_pkg::PCT_FULL) // RULE11
                            : (32'(a) * 32'(mfb_pkg::PCT_FULL)) / 32'(b);
      mfb_pkg::OP_MIN: wide = (a < b) ? 32'(a) : 32'(b);
      mfb_pkg::OP_MAX: wide = (a > b) ? 32'(a) : 32'(b);
      default:         y = '0;
    endcase
    if (op >= 4'(mfb_pkg::OP_ADD)) begin
      // saturate to full scale
      y = (wide > 32'(mfb_pkg::PCT_FULL)) ? mfb_pkg::PCT_FULL : wide[15:0]; // RULE10
    end
  end
endmodule

//--- verilog/mfb_top.sv
// five independent math function blocks of four chained stages behind an AXI4-Lite register port
// assumes sig_in comes from logic on aclk and is sampled once per update tick
//
// What this block does
// RULE1 - five independent math blocks exist, each with its own configuration words.
// RULE2 - each block has six inputs, each picked from the signal sources by a source index.
// RULE3 - each input becomes a percentage of its span between its own minimum and maximum.
// RULE4 - each scaled input is multiplied by its own gain.
// RULE5 - each stage result feeds operand A of the next, giving a left-nested chain.
// RULE6 - stage one picks both operands, stages two to four pick only operand B.
// RULE7 - a stage whose operand B is not used passes operand A unchanged.
// RULE8 - each stage picks its operation by code and logical or relational codes give only false or true.
// RULE9 - OR, AND and XOR treat an operand of at least one percent as true.
// RULE10 - arithmetic results saturate to the range of zero to full scale.
// RULE11 - a divide by zero gives full scale for that stage.
// RULE12 - arithmetic codes give sum, difference, product, quotient, minimum and maximum, code 9 adding.
// RULE13 - XOR is true when exactly one operand is true.
// RULE14 - the final percentage maps linearly onto the output minimum to maximum range.
// RULE15 - the output minimum and maximum are offered to consumers as the signal limits.
// RULE16 - codes 0 to 5 compare and codes 6 to 14 are OR, AND, XOR, add, subtract, multiply, divide, min, max.
// RULE17 - all blocks are recomputed once per update tick from inputs sampled at the tick; the code recomputes only blocks enabled in the control register.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mfb_top #(
  parameter int UPDATE_CYC = 2500
) (
  input  wire logic                                           aclk,
  input  wire logic                                           aresetn,
  input  wire logic [mfb_pkg::AXI_AW-1:0]                     s_axi_awaddr,
  input  wire logic                                           s_axi_awvalid,
  output      logic                                           s_axi_awready,
  input  wire logic [31:0]                                    s_axi_wdata,
  input  wire logic [3:0]                                     s_axi_wstrb,
  input  wire logic                                           s_axi_wvalid,
  output      logic                                           s_axi_wready,
  output      logic [1:0]                                     s_axi_bresp,
  output      logic                                           s_axi_bvalid,
  input  wire logic                                           s_axi_bready,
  input  wire logic [mfb_pkg::AXI_AW-1:0]                     s_axi_araddr,
  input  wire logic                                           s_axi_arvalid,
  output      logic                                           s_axi_arready,
  output      logic [31:0]                                    s_axi_rdata,
  output      logic [1:0]                                     s_axi_rresp,
  output      logic                                           s_axi_rvalid,
  input  wire logic                                           s_axi_rready,
  input  wire logic [mfb_pkg::NUM_SRC-1:0][15:0]              sig_in,
  output      logic [mfb_pkg::NUM_INST-1:0][15:0]             math_out,
  output      logic [mfb_pkg::NUM_INST-1:0][15:0]             out_min,
  output      logic [mfb_pkg::NUM_INST-1:0][15:0]             out_max,
  output      logic                                           math_upd
);
  localparam logic [2:0]  LAST_INST = 3'(mfb_pkg::NUM_INST - 1);
  localparam logic [35:0] FULL_W    = 36'(mfb_pkg::PCT_FULL);

  mfb_pkg::mfb_state_type                 st_q;
  logic [2:0]                             inst_q;
  logic [4:0]                             step_q;
  logic [mfb_pkg::NUM_INST-1:0]           en_q;
  logic [31:0]                            tick_cnt_q;
  logic                                   tick_q;
  logic [mfb_pkg::NUM_SRC-1:0][15:0]      snap_q;
  mfb_pkg::mfb_lim_type                   lim_q;
  logic [mfb_pkg::NUM_IN-1:0][15:0]       pct_q;
  logic [15:0]                            acc_q;
  logic [mfb_pkg::AXI_AW-1:0]             awaddr_q;
  logic [31:0]                            wdata_q;
  logic [3:0]                             wstrb_q;
  logic [mfb_pkg::AXI_AW-1:0]             araddr_q;
  logic [1:0]                             rd_sh_q;
  logic [31:0]                            mem_rdata_a;
  logic [31:0]                            mem_rdata_b;
  logic                                   do_wr;
  logic                                   wr_cfg;
  logic                                   wr_ok;
  logic [31:0]                            rd_data;
  logic                                   rd_err;
  logic                                   exec_in;
  logic                                   exec_stg;
  logic                                   exec_out;
  logic                                   cycle_done;
  mfb_pkg::mfb_src_type                   sw;
  mfb_pkg::mfb_stage_type                 stg;
  mfb_pkg::mfb_lim_type                   ow;
  logic [15:0]                            x;
  logic [15:0]                            span;
  logic [31:0]                            scaled;
  logic [31:0]                            gained;
  logic [15:0]                            opa;
  logic [15:0]                            opb;
  logic [15:0]                            alu_y;
  logic signed [17:0]                     odiff;
  logic signed [35:0]                     oprod;
  logic signed [35:0]                     oval;

  // ---------------- AXI4-Lite write side
  assign do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_cfg = awaddr_q < mfb_pkg::CFG_END;
  assign wr_ok  = wr_cfg || awaddr_q[11:2] == mfb_pkg::CTRL_ADDR[11:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mfb_pkg::RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? mfb_pkg::RESP_OKAY : mfb_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // per-block enables; memory is not reset so nothing runs until software enables it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= '0;
    end else if (do_wr && awaddr_q[11:2] == mfb_pkg::CTRL_ADDR[11:2] && wstrb_q[0]) begin
      en_q <= wdata_q[mfb_pkg::NUM_INST-1:0];
    end
  end

  // ---------------- AXI4-Lite read side: two cycles for the memory's registered port
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (araddr_q < mfb_pkg::CFG_END) begin
      rd_data = mem_rdata_a;
    end else if (araddr_q >= mfb_pkg::RES_BASE && araddr_q < mfb_pkg::RES_END) begin
      rd_data = 32'(math_out[araddr_q[4:2]]);
    end else if (araddr_q[11:2] == mfb_pkg::CTRL_ADDR[11:2]) begin
      rd_data = 32'(en_q);
    end else if (araddr_q[11:2] == mfb_pkg::STAT_ADDR[11:2]) begin
      rd_data = {29'h0, inst_q != 3'h0 || st_q != mfb_pkg::ST_IDLE, 2'(st_q)};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= mfb_pkg::RESP_OKAY;
      araddr_q      <= '0;
      rd_sh_q       <= '0;
    end else begin
      rd_sh_q <= {rd_sh_q[0], s_axi_arvalid && s_axi_arready};
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q      <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_sh_q[1]) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? mfb_pkg::RESP_SLVERR : mfb_pkg::RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  mfb_cfg_mem #(
    .DEPTH (mfb_pkg::MEM_DEPTH),
    .AW    (mfb_pkg::MEM_AW)
  ) u_mem (
    .clk     (aclk),
    .we      (do_wr && wr_cfg),
    .waddr   (awaddr_q[9:2]),
    .wdata   (wdata_q),
    .wstrb   (wstrb_q),
    .raddr_a (araddr_q[9:2]),
    .rdata_a (mem_rdata_a),
    .raddr_b ({inst_q, step_q}), // RULE1
    .rdata_b (mem_rdata_b)
  );

  // ---------------- update tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= tick_cnt_q == 32'(UPDATE_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(UPDATE_CYC - 1)) ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // ---------------- sequencer: fetch one word, execute it, for each enabled block
  assign exec_in    = st_q == mfb_pkg::ST_EXEC && step_q < mfb_pkg::STEP_STG0;
  assign exec_stg   = st_q == mfb_pkg::ST_EXEC && step_q >= mfb_pkg::STEP_STG0 && step_q < mfb_pkg::STEP_OUT;
  assign exec_out   = st_q == mfb_pkg::ST_EXEC && step_q == mfb_pkg::STEP_OUT;
  assign cycle_done = inst_q == LAST_INST && (exec_out || (st_q == mfb_pkg::ST_FETCH && !en_q[inst_q]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= mfb_pkg::ST_IDLE;
      inst_q <= '0;
      step_q <= mfb_pkg::STEP_FIRST;
    end else begin
      unique case (st_q)
        mfb_pkg::ST_IDLE: if (tick_q) begin // RULE17
          inst_q <= '0;
          step_q <= mfb_pkg::STEP_FIRST;
          st_q   <= mfb_pkg::ST_FETCH;
        end
        mfb_pkg::ST_FETCH: if (!en_q[inst_q]) begin
          inst_q <= (inst_q == LAST_INST) ? '0 : inst_q + 3'h1;
          st_q   <= (inst_q == LAST_INST) ? mfb_pkg::ST_IDLE : mfb_pkg::ST_FETCH;
        end else begin
          st_q <= mfb_pkg::ST_EXEC;
        end
        mfb_pkg::ST_EXEC: if (step_q == mfb_pkg::STEP_OUT) begin
          step_q <= mfb_pkg::STEP_FIRST;
          inst_q <= (inst_q == LAST_INST) ? '0 : inst_q + 3'h1;
          st_q   <= (inst_q == LAST_INST) ? mfb_pkg::ST_IDLE : mfb_pkg::ST_FETCH;
        end else begin
          step_q <= step_q + 5'h1;
          st_q   <= mfb_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // ---------------- datapath
  function automatic logic [15:0] pick(input logic [3:0] k);
    pick = (k == 4'h0 || int'(k) > mfb_pkg::NUM_IN) ? '0 : pct_q[k - 4'h1];
  endfunction

  always_comb begin
    sw     = mfb_pkg::mfb_src_type'(mem_rdata_b);
    stg    = mfb_pkg::mfb_stage_type'(mem_rdata_b);
    ow     = mfb_pkg::mfb_lim_type'(mem_rdata_b);
    x      = (sw.src == 8'h0 || int'(sw.src) > mfb_pkg::NUM_SRC) ? '0 : snap_q[sw.src[3:0] - 4'h1]; // RULE2
    span   = lim_q.max - lim_q.min;
    scaled = '0;
    if (lim_q.max <= lim_q.min || x <= lim_q.min) begin
      scaled = '0;
    end else if (x >= lim_q.max) begin
      scaled = 32'(mfb_pkg::PCT_FULL);
    end else begin
      scaled = (32'(x - lim_q.min) * 32'(mfb_pkg::PCT_FULL)) / 32'(span); // RULE3
    end
    gained = (scaled * 32'(sw.gain)) >> mfb_pkg::GAIN_FRAC; // RULE4
    opa    = (step_q == mfb_pkg::STEP_STG0) ? pick(stg.srca) : acc_q; // RULE5 RULE6
    opb    = pick(stg.srcb); // RULE6
    odiff  = $signed({2'b00, ow.max}) - $signed({2'b00, ow.min});
    oprod  = $signed({20'h0, acc_q}) * 36'(odiff);
    oval   = $signed({20'h0, ow.min}) + oprod / $signed(FULL_W); // RULE14
  end

  mfb_alu u_alu (
    .a  (opa),
    .b  (opb),
    .op (stg.op),
    .y  (alu_y)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_q <= '0;
    end else if (st_q == mfb_pkg::ST_IDLE && tick_q) begin
      snap_q <= sig_in; // RULE17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_q <= '0;
      pct_q <= '0;
      acc_q <= '0;
    end else begin
      if (exec_in && !step_q[0]) begin
        lim_q <= mfb_pkg::mfb_lim_type'(mem_rdata_b);
      end
      if (exec_in && step_q[0]) begin
        pct_q[step_q[4:1]] <= (gained > 32'(mfb_pkg::VAL_MAX)) ? mfb_pkg::VAL_MAX : gained[15:0];
      end
      if (exec_stg) begin
        acc_q <= (stg.srcb == 4'h0) ? opa : alu_y; // RULE7
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      math_out <= '0;
      out_min  <= '0;
      out_max  <= '0;
      math_upd <= 1'b0;
    end else begin
      math_upd <= cycle_done;
      if (exec_out) begin
        math_out[inst_q] <= oval[15:0]; // RULE14
        out_min[inst_q]  <= ow.min; // RULE15
        out_max[inst_q]  <= ow.max; // RULE15
      end
    end
  end

  // ---------------- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_bypass;
    exec_stg && stg.srcb == 4'h0 |=> acc_q == $past(opa);
  endproperty
  a_bypass: assert property (p_bypass) else $error("stage without operand b did not pass a"); // RULE7

  property p_logic;
    exec_stg && stg.srcb != 4'h0 && stg.op <= 4'(mfb_pkg::OP_XOR) |=> acc_q == '0 || acc_q == mfb_pkg::PCT_UNIT;
  endproperty
  a_logic: assert property (p_logic) else $error("logical stage gave a non boolean value"); // RULE8

  property p_sat;
    exec_stg && stg.srcb != 4'h0 && stg.op >= 4'(mfb_pkg::OP_ADD) |=> acc_q <= mfb_pkg::PCT_FULL;
  endproperty
  a_sat: assert property (p_sat) else $error("arithmetic stage above full scale"); // RULE10

  property p_div0;
    exec_stg && stg.srcb != 4'h0 && stg.op == 4'(mfb_pkg::OP_DIV) && opb == '0 |=> acc_q == mfb_pkg::PCT_FULL;
  endproperty
  a_div0: assert property (p_div0) else $error("divide by zero not full scale"); // RULE11

  property p_add;
    exec_stg && stg.srcb != 4'h0 && stg.op == 4'(mfb_pkg::OP_ADD) && 17'(opa) + 17'(opb) <= 17'(mfb_pkg::PCT_FULL)
      |=> acc_q == $past(opa) + $past(opb);
  endproperty
  a_add: assert property (p_add) else $error("add stage gave a wrong sum"); // RULE12

  property p_chain;
    exec_stg && step_q != mfb_pkg::STEP_STG0 |-> opa == acc_q;
  endproperty
  a_chain: assert property (p_chain) else $error("later stage not fed by previous result"); // RULE5

  property p_sample;
    st_q == mfb_pkg::ST_IDLE && tick_q |=> snap_q == $past(sig_in) && st_q == mfb_pkg::ST_FETCH;
  endproperty
  a_sample: assert property (p_sample) else $error("inputs not sampled at the tick"); // RULE17

  property p_outzero;
    exec_out && acc_q == '0 |=> math_out[$past(inst_q)] == $past(ow.min) && out_max[$past(inst_q)] == $past(ow.max);
  endproperty
  a_outzero: assert property (p_outzero) else $error("zero percent not mapped to output minimum"); // RULE14 RULE15

  property p_scale0;
    exec_in && step_q[0] && x <= lim_q.min |=> pct_q[$past(step_q[4:1])] == '0;
  endproperty
  a_scale0: assert property (p_scale0) else $error("input below minimum not zero percent"); // RULE3

  property p_bresp;
    s_wr_both |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing after both channels");

  // response stands with its code until the master takes it
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped before it was taken");

  property p_rdlat;
    s_rd_taken |-> ##3 s_axi_rvalid;
  endproperty
  a_rdlat: assert property (p_rdlat) else $error("read data not on the third edge");
endmodule

//--- sim/mfb_src_model.sv
// signal sources feeding the math blocks: two live values, the rest a moving pattern
// assumes the bench sets val_a and val_b; all on aclk
`timescale 1ns/1ps
module mfb_src_model (
  input  wire logic                              aclk,
  input  wire logic [15:0]                       val_a,
  input  wire logic [15:0]                       val_b,
  output      logic [mfb_pkg::NUM_SRC-1:0][15:0] sig_in
);
  logic [15:0] pat_q = 16'h5a5a;

  // idle sources keep changing so a wrong source pick never reads a steady value
  always_ff @(posedge aclk) begin
    pat_q  <= ~pat_q;
    sig_in <= {{(mfb_pkg::NUM_SRC - 2){pat_q}}, val_b, val_a};
  end
endmodule

//--- sim/testbench.sv
// self-checking bench: AXI4-Lite set-up of block 0, operator sweep, chain and output range
// assumes the design answers every request; a cycle ceiling cuts hangs short
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic                                   aclk, aresetn;
  logic [11:0]                            s_axi_awaddr, s_axi_araddr;
  logic                                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                                   s_axi_rvalid, s_axi_rready, math_upd;
  logic [31:0]                            s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]                             s_axi_wstrb;
  logic [1:0]                             s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0]                            val_a, val_b;
  logic [mfb_pkg::NUM_SRC-1:0][15:0]      sig_in;
  logic [mfb_pkg::NUM_INST-1:0][15:0]     math_out, out_min, out_max;
  int                                     num_errors, compares, cyc;
  int                                     pa[3] = '{2000, 8000, 50};
  int                                     pb[3] = '{3000, 5000, 0};
  logic [31:0]                            cfg[17] = '{32'h2710_0000, 32'h0100_0001, 32'h2710_0000,
    32'h0100_0002, 0, 0, 0, 0, 0, 0, 0, 0, 32'h0000_0219, 32'h9, 32'h9, 32'h9, 32'h2710_0000};

  mfb_top #(.UPDATE_CYC(40)) mfb_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sig_in, .math_out, .out_min, .out_max, .math_upd);
  mfb_src_model mfb_src_model_i (.aclk, .val_a, .val_b, .sig_in);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic close_out();
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdv = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // two pulses: the second pass is snapshotted wholly after the change
  task automatic run(input logic [15:0] a, input logic [15:0] b);
    int n;
    val_a <= a; val_b <= b;
    n = 0;
    while (n < 2) begin
      @(posedge aclk);
      if (math_upd === 1'b1) n++;
    end
  endtask

  function automatic logic [15:0] f(input int op, input int a, input int b);
    int r;
    case (op)
      0: r = 100 * (a == b);   1: r = 100 * (a != b);  2: r = 100 * (a > b);
      3: r = 100 * (a >= b);   4: r = 100 * (a < b);   5: r = 100 * (a <= b);
      6: r = 100 * (a >= 100 || b >= 100);  7: r = 100 * (a >= 100 && b >= 100);
      8: r = 100 * ((a >= 100) != (b >= 100));  9: r = a + b;  10: r = a > b ? a - b : 0;
      11: r = a * b / 10000;   12: r = b == 0 ? 10000 : a * 10000 / b;  13: r = a < b ? a : b;
      default: r = a > b ? a : b;
    endcase
    return 16'(r > 10000 ? 10000 : r);
  endfunction

  initial begin
    aresetn = 1'b0; s_axi_awaddr = 0; s_axi_awvalid = 0; s_axi_wdata = 0; s_axi_wstrb = 0;
    s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 0; s_axi_arvalid = 0; s_axi_rready = 0;
    val_a = 0; val_b = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int w = 0; w < 17; w++) wr(12'(4 * w), cfg[w]);
    wr(12'h480, 32'h1);
    for (int p = 0; p < 3; p++) begin
      for (int op = 0; op < 15; op++) begin
        wr(12'h030, 32'h210 | 32'(op));
        run(16'(pa[p]), 16'(pb[p]));
        `CHK(math_out[0], f(op, pa[p], pb[p]))
      end
    end
    rd(12'h400);
    `CHK(rdv, 32'h0000_0032)
    wr(12'h004, 32'h0200_0001);
    wr(12'h008, 32'h0bb8_03e8);
    wr(12'h034, 32'h0000_0109);
    wr(12'h030, 32'h0000_0219);
    run(16'd1000, 16'd2000);
    `CHK(math_out[0], 16'd9000)
    wr(12'h040, 32'h0bb8_03e8);
    run(16'd1000, 16'd2000);
    `CHK(math_out[0], 16'd2800)
    `CHK(out_min[0], 16'd1000)
    `CHK(out_max[0], 16'd3000)
    for (int w = 0; w < 17; w++) wr(12'h200 + 12'(4 * w), cfg[w]);
    wr(12'h480, 32'h11);
    rd(12'h480);
    `CHK(rdv, 32'h0000_0011)
    run(16'd3000, 16'd4000);
    rd(12'h410);
    `CHK(rdv, 32'd7000)
    `CHK(math_out[0], 16'd3000)
    wr(12'h400, 32'h0);
    `CHK(rsp, mfb_pkg::RESP_SLVERR)
    rd(12'h300);
    `CHK(rsp, mfb_pkg::RESP_SLVERR)
    close_out();
  end
endmodule
